/* File: cbc_pkg.sv */
// package: register map, field layout, states and carriers of the balance control block
package cbc_pkg;

   // register index space; byte address is four times the index
   localparam int          CBC_IDX_W        = 12;
   localparam int          CBC_HI_LSB       = 14;
   localparam logic [11:0] CBC_CTRL_IDX     = 12'h32f;
   localparam logic [11:0] CBC_STAT_IDX     = 12'h340;
   localparam logic [11:0] CBC_DONE_IDX     = 12'h341;

   // balance_control_two field positions
   localparam int          CBC_PAUSE_BIT    = 6;
   localparam int          CBC_FLTSTOP_BIT  = 5;
   localparam int          CBC_BALANCING_OVERHEAT_BIT     = 4;
   localparam int          CBC_ACT_MSB      = 3;
   localparam int          CBC_ACT_LSB      = 2;
   localparam int          CBC_START_BIT    = 1;
   localparam int          CBC_AUTO_BIT     = 0;
   localparam logic [7:0]  CBC_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  CBC_CTRL_WMASK   = 8'h7d;

   localparam int          CBC_CELLS        = 16;

   typedef enum logic [1:0] {
      CBC_ACT_NONE  = 2'b00,
      CBC_ACT_SLEEP = 2'b01,
      CBC_ACT_SHUT  = 2'b10,
      CBC_ACT_RSVD  = 2'b11
   } cbc_act_t;

   typedef enum logic [1:0] {
      CBC_IDLE = 2'b00,
      CBC_RUN  = 2'b01,
      CBC_HALT = 2'b10,
      CBC_DONE = 2'b11
   } cbc_run_t;

   // settings captured by a start
   typedef struct packed {
      logic     fault_halt_enable;
      logic     balance_overheat_detect_enable;
      cbc_act_t post_balance_action;
      logic     automatic_mode_select;
   } cbc_cfg_t;

   // register access from the bus front end
   typedef struct packed {
      logic        wr;
      logic [11:0] idx;
      logic [31:0] wdata;
   } cbc_req_t;

   typedef struct packed {
      logic        wr;
      logic        rd_wait;
      logic        mapped;
      logic [11:0] idx;
      logic [31:0] rdata;
   } cbc_bus_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      cbc_cfg_t    cfg;
      cbc_run_t    run;
      logic [15:0] done;
      logic        strobe;
      logic        sleep;
      logic        shut;
   } cbc_state_t;

endpackage

/* File: cbc_ahb_slave.sv */
// AHB-Lite slave front end: address phase capture, write strobe, one-wait-state reads
`timescale 1ns/1ns
module cbc_ahb_slave (
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // register side
   output cbc_pkg::cbc_req_t      req,
   input  wire logic [31:0]       rdata
);
   import cbc_pkg::*;

   cbc_bus_t q, d;

   always_comb begin
      d = q;
      if (q.rd_wait) begin
         // wait state lets a write just before the read land first
         d.rdata   = q.mapped ? rdata : 32'h0000_0000;
         d.rd_wait = 1'b0;
      end
      if (hready) begin
         d.wr = 1'b0;
         if (hsel && htrans[1]) begin
            d.wr      = hwrite;
            d.rd_wait = !hwrite;
            d.idx     = haddr[CBC_HI_LSB-1:2];
            d.mapped  = (haddr[31:CBC_HI_LSB] == '0);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // only whole words are expected; hsize does not change the access
   assign hreadyout = !q.rd_wait;
   assign hresp     = 1'b0;
   assign hrdata    = q.rdata;
   assign req.wr    = q.wr && q.mapped;
   assign req.idx   = q.idx;
   assign req.wdata = hwdata;

endmodule

/* File: cbc_top.sv */
// balance control register bank: start capture, pause, fault halt, post-balance action
// Functional notes
// - control bit 6 set pauses balancing on every cell; clear runs normally.
// - bit 5 set halts all balancing on unmasked fault; clear ignores faults but thermal.
// - bit 4 enables balancing overheat detection while balancing runs.
// - writing start bit 1 begins balancing and captures the settings in bits 5, 4, 3:2 and 0; pause bit 6 is not captured.
// - later edits of the captured settings are ignored until start is written again; pause takes effect at once.
// - start bit clears itself and always reads back zero.
// - bit 0 picks manual or automatic balancing, captured at start.
// - a start clears every per-cell completion flag except those set by a completion event in the same cycle.
`timescale 1ns/1ns
module cbc_top (
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // events from balancing logic
   input  wire logic                  fault_unmasked,
   input  wire logic                  thermal_shutdown,
   input  wire logic [15:0]           cell_done_event,
   input  wire logic                  all_balancing_done,
   // balancing control
   output logic                       balance_start_strobe,
   output logic                       balance_enable,
   output logic                       pause_all_balancing,
   output logic                       balance_halted,
   output logic                       balance_overheat_detect_enable,
   output logic                       automatic_mode_select,
   output logic                       sleep_request,
   output logic                       shutdown_request,
   output logic [15:0]                cell_completion_flag
);
   import cbc_pkg::*;

   cbc_req_t    req;
   logic [31:0] rdata;
   cbc_state_t  q, d;
   logic        ctrl_wr;
   logic        start;
   cbc_cfg_t    wcfg;

   cbc_ahb_slave i_cbc_ahb_slave (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .req       (req),
      .rdata     (rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register writes and run control

   assign ctrl_wr = req.wr && (req.idx == CBC_CTRL_IDX);
   assign start   = ctrl_wr && req.wdata[CBC_START_BIT];
   assign wcfg    = '{fault_halt_enable:              req.wdata[CBC_FLTSTOP_BIT],
                      balance_overheat_detect_enable: req.wdata[CBC_BALANCING_OVERHEAT_BIT],
                      post_balance_action:            cbc_act_t'(req.wdata[CBC_ACT_MSB:CBC_ACT_LSB]),
                      automatic_mode_select:          req.wdata[CBC_AUTO_BIT]};

   always_comb begin
      d        = q;
      d.strobe = 1'b0;
      d.sleep  = 1'b0;
      d.shut   = 1'b0;
      if (ctrl_wr) begin
         // start bit never stored, so it reads zero
         d.ctrl = req.wdata[7:0] & CBC_CTRL_WMASK;
      end
      if (start) begin
         d.cfg    = wcfg;
         d.done   = '0;
         d.run    = CBC_RUN;
         d.strobe = 1'b1;
      end else begin
         // settings stay as captured until the next start
         case (q.run)
            CBC_RUN: begin
               if (thermal_shutdown || (q.cfg.fault_halt_enable && fault_unmasked)) begin
                  d.run = CBC_HALT;
               end else if (all_balancing_done) begin
                  d.run   = CBC_DONE;
                  d.sleep = (q.cfg.post_balance_action == CBC_ACT_SLEEP);
                  d.shut  = (q.cfg.post_balance_action == CBC_ACT_SHUT);
               end
            end
            CBC_IDLE, CBC_HALT, CBC_DONE: begin
               d.run = q.run;
            end
            default: begin
               d.run = CBC_IDLE;
            end
         endcase
      end
      // a completion arriving with a start is kept
      d.done = d.done | cell_done_event;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q      <= '0;
         q.ctrl <= CBC_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux and outputs

   always_comb begin
      case (req.idx)
         CBC_CTRL_IDX: rdata = {24'h00_0000, q.ctrl};
         CBC_STAT_IDX: rdata = {25'h000_0000, q.cfg, q.run};
         CBC_DONE_IDX: rdata = {16'h0000, q.done};
         default:      rdata = 32'h0000_0000;
      endcase
   end

   assign balance_start_strobe           = q.strobe;
   assign pause_all_balancing            = q.ctrl[CBC_PAUSE_BIT];
   assign balance_enable                 = (q.run == CBC_RUN) && !q.ctrl[CBC_PAUSE_BIT];
   assign balance_halted                 = (q.run == CBC_HALT);
   assign balance_overheat_detect_enable = q.cfg.balance_overheat_detect_enable && (q.run == CBC_RUN);
   assign automatic_mode_select          = q.cfg.automatic_mode_select;
   assign sleep_request                  = q.sleep;
   assign shutdown_request               = q.shut;
   assign cell_completion_flag           = q.done;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_start_pulse;
      start |=> balance_start_strobe && (q.run == CBC_RUN);
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start did not pulse strobe and run");

   property p_start_reads_zero;
      ctrl_wr |=> (q.ctrl[CBC_START_BIT] == 1'b0) && (q.ctrl[CBC_PAUSE_BIT] == $past(req.wdata[CBC_PAUSE_BIT]));
   endproperty
   a_start_reads_zero: assert property (p_start_reads_zero) else $error("start bit read back nonzero");

   property p_pause_blocks;
      pause_all_balancing |-> !balance_enable;
   endproperty
   a_pause_blocks: assert property (p_pause_blocks) else $error("balancing enabled while paused");

   property p_fault_halts;
      (q.run == CBC_RUN) && q.cfg.fault_halt_enable && fault_unmasked && !start |=> balance_halted && !balance_enable;
   endproperty
   a_fault_halts: assert property (p_fault_halts) else $error("unmasked fault did not halt");

   property p_fault_ignored;
      (q.run == CBC_RUN) && !q.cfg.fault_halt_enable && !thermal_shutdown && !all_balancing_done && !start
         |=> (q.run == CBC_RUN);
   endproperty
   a_fault_ignored: assert property (p_fault_ignored) else $error("balancing stopped without cause");

   property p_overheat_enable;
      start |=> (balance_overheat_detect_enable == $past(req.wdata[CBC_BALANCING_OVERHEAT_BIT]));
   endproperty
   a_overheat_enable: assert property (p_overheat_enable) else $error("overheat detect enable not captured");

   property p_cfg_held;
      !start |=> $stable(q.cfg);
   endproperty
   a_cfg_held: assert property (p_cfg_held) else $error("settings changed without start");

   property p_auto_capture;
      start |=> (automatic_mode_select == $past(req.wdata[CBC_AUTO_BIT]));
   endproperty
   a_auto_capture: assert property (p_auto_capture) else $error("mode select not captured");

   property p_post_action;
      (q.run == CBC_RUN) && all_balancing_done && !thermal_shutdown && !fault_unmasked && !start
         |=> (sleep_request == (q.cfg.post_balance_action == CBC_ACT_SLEEP))
             && (shutdown_request == (q.cfg.post_balance_action == CBC_ACT_SHUT)) ##1 !sleep_request && !shutdown_request;
   endproperty
   a_post_action: assert property (p_post_action) else $error("wrong post-balance action");

   property p_done_cleared;
      start && (cell_done_event == 16'h0000) |=> (cell_completion_flag == 16'h0000);
   endproperty
   a_done_cleared: assert property (p_done_cleared) else $error("completion flags not cleared by start");

   // a completion landing with the start must survive the clear
   property p_flag_set_wins;
      start && (cell_done_event != 16'h0000) |=> (cell_completion_flag == $past(cell_done_event));
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("completion set lost to start clear");

   property p_flags_sticky;
      !start |=> ((cell_completion_flag & $past(cell_completion_flag)) == $past(cell_completion_flag));
   endproperty
   a_flags_sticky: assert property (p_flags_sticky) else $error("completion flag dropped without start");

   property p_power_source;
      sleep_request || shutdown_request |-> (q.run == CBC_DONE) && !(sleep_request && shutdown_request);
   endproperty
   a_power_source: assert property (p_power_source) else $error("power request outside balancing end");

   c_start:  cover property (start ##1 balance_enable);
   c_halt:   cover property ((q.run == CBC_RUN) ##[1:50] balance_halted);
   c_sleep:  cover property (start ##[1:50] sleep_request);
   c_pause:  cover property (balance_start_strobe ##[1:50] pause_all_balancing);
   c_shut:   cover property (start ##[1:50] shutdown_request);

endmodule

/* File: cell_balance_control_tb.sv */
// self-checking testbench for the balance control register bank
`timescale 1ns/1ns
module cell_balance_control_tb;
   import cbc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        fault_unmasked, thermal_shutdown, all_balancing_done;
   logic [15:0] cell_done_event, cell_completion_flag;
   logic        balance_start_strobe, balance_enable, pause_all_balancing, balance_halted;
   logic        balance_overheat_detect_enable, automatic_mode_select, sleep_request, shutdown_request;
   int          fails, total_checks;
   localparam logic [31:0] A_CTRL = {18'h0, CBC_CTRL_IDX, 2'b00};
   localparam logic [31:0] A_STAT = {18'h0, CBC_STAT_IDX, 2'b00};
   localparam logic [31:0] A_DONE = {18'h0, CBC_DONE_IDX, 2'b00};
   localparam logic [31:0] A_BAD  = 32'h0001_0cbc;

   cbc_top i_cbc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fault_unmasked(fault_unmasked), .thermal_shutdown(thermal_shutdown),
      .cell_done_event(cell_done_event), .all_balancing_done(all_balancing_done),
      .balance_start_strobe(balance_start_strobe), .balance_enable(balance_enable),
      .pause_all_balancing(pause_all_balancing), .balance_halted(balance_halted),
      .balance_overheat_detect_enable(balance_overheat_detect_enable),
      .automatic_mode_select(automatic_mode_select), .sleep_request(sleep_request),
      .shutdown_request(shutdown_request), .cell_completion_flag(cell_completion_flag));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask

   // values are taken at the negedge before the sampling edge, so no race with the flops
   task wait_rdy();
      int   n;
      logic r;
      n = 0;
      do begin
         @(negedge hclk);
         r = hreadyout;
         rd = hrdata;
         @(posedge hclk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) begin
         fails++;
         end_of_test();
      end
   endtask

   // entered and left just after a rising edge
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task rdchk(input string n, input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(n, rd, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task t_reset();
      rdchk("ctrl", A_CTRL, {24'h0, CBC_CTRL_RESET});
      rdchk("stat", A_STAT, 32'h0);
      rdchk("flags", A_DONE, 32'h0);
      chk("resp", {31'h0, hresp}, 32'h0);
      $display("test reset done");
   endtask

   task t_start();
      xfer(1'b1, A_CTRL, 32'h33);
      @(negedge hclk);
      chk("strobe", {31'h0, balance_start_strobe}, 32'h1);
      chk("enable", {31'h0, balance_enable}, 32'h1);
      chk("auto", {31'h0, automatic_mode_select}, 32'h1);
      chk("otdet", {31'h0, balance_overheat_detect_enable}, 32'h1);
      @(posedge hclk);
      @(negedge hclk);
      chk("strobe_end", {31'h0, balance_start_strobe}, 32'h0);
      @(posedge hclk);
      rdchk("ctrl", A_CTRL, 32'h31);
      rdchk("stat", A_STAT, 32'h65);
      $display("test start done");
   endtask

   task t_capture();
      xfer(1'b1, A_CTRL, 32'h40);
      @(negedge hclk);
      chk("pause", {31'h0, pause_all_balancing}, 32'h1);
      chk("enable", {31'h0, balance_enable}, 32'h0);
      chk("auto", {31'h0, automatic_mode_select}, 32'h1);
      chk("otdet", {31'h0, balance_overheat_detect_enable}, 32'h1);
      @(posedge hclk);
      xfer(1'b1, A_CTRL, 32'h00);
      @(negedge hclk);
      chk("resume", {31'h0, balance_enable}, 32'h1);
      @(posedge hclk);
      xfer(1'b1, A_BAD, 32'h7d);
      rdchk("unmapped", A_BAD, 32'h0);
      rdchk("ctrl", A_CTRL, 32'h0);
      rdchk("stat", A_STAT, 32'h65);
      $display("test capture done");
   endtask

   task t_fault();
      xfer(1'b1, A_CTRL, 32'h02);
      fault_unmasked <= 1'b1;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      chk("no_halt", {31'h0, balance_halted}, 32'h0);
      chk("enable", {31'h0, balance_enable}, 32'h1);
      @(posedge hclk);
      thermal_shutdown <= 1'b1;
      @(posedge hclk);
      @(negedge hclk);
      chk("thermal", {31'h0, balance_halted}, 32'h1);
      @(posedge hclk);
      thermal_shutdown <= 1'b0;
      fault_unmasked <= 1'b0;
      xfer(1'b1, A_CTRL, 32'h22);
      fault_unmasked <= 1'b1;
      @(posedge hclk);
      @(negedge hclk);
      chk("halt", {31'h0, balance_halted}, 32'h1);
      chk("halt_en", {31'h0, balance_enable}, 32'h0);
      @(posedge hclk);
      fault_unmasked <= 1'b0;
      $display("test fault done");
   endtask

   task t_action();
      logic [3:0] s;
      logic [3:0] z;
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, A_CTRL, 32'h02 | (c << 2));
         all_balancing_done <= 1'b1;
         // one sample per cycle; the pulse is due in the second one only
         for (int i = 0; i < 4; i++) begin
            @(negedge hclk);
            s[i] = sleep_request;
            z[i] = shutdown_request;
            @(posedge hclk);
         end
         all_balancing_done <= 1'b0;
         chk("sleep", {28'h0, s}, (c == 1) ? 32'h2 : 32'h0);
         chk("shut", {28'h0, z}, (c == 2) ? 32'h2 : 32'h0);
         rdchk("stat_act", A_STAT, 32'h03 | (c << 3));
      end
      $display("test action done");
   endtask

   task t_flags();
      cell_done_event <= 16'h8001;
      @(posedge hclk);
      cell_done_event <= 16'h0000;
      rdchk("flags", A_DONE, 32'h8001);
      chk("flag_out", {16'h0, cell_completion_flag}, 32'h8001);
      xfer(1'b1, A_CTRL, 32'h02);
      @(negedge hclk);
      chk("cleared", {16'h0, cell_completion_flag}, 32'h0);
      @(posedge hclk);
      rdchk("flags_rd", A_DONE, 32'h0);
      $display("test flags done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      total_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fault_unmasked = 1'b0;
      thermal_shutdown = 1'b0;
      all_balancing_done = 1'b0;
      cell_done_event = 16'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_start();
      t_capture();
      t_fault();
      t_action();
      t_flags();
      end_of_test();
   end
endmodule
